// ---- rtmr_params.svh ----
`ifndef RTMR_PARAMS_SVH
`define RTMR_PARAMS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define RTMR_OFF_CTRL     8'h00
`define RTMR_OFF_COUNT    8'h01
`define RTMR_OFF_RELOAD   8'h02
`define RTMR_OFF_STATUS   8'h03
`define RTMR_OFF_MASK     8'h04
// ----------------------------------------
// control field positions
// ----------------------------------------
`define RTMR_CTRL_EN      0
`define RTMR_CTRL_MODE_LO 1
`define RTMR_CTRL_MODE_HI 2
`define RTMR_CTRL_PRE_LO  3
`define RTMR_CTRL_PRE_HI  5
`define RTMR_CTRL_POL     6
`define RTMR_CTRL_OUTEN   7
// ----------------------------------------
// reset and reload values
// ----------------------------------------
`define RTMR_CTRL_RST     8'h00
`define RTMR_COUNT_RST    16'h0000
`define RTMR_RELOAD_RST   16'h0000
`define RTMR_COUNT_RESTART 16'h0001
`define RTMR_PRE_MAX_LOG  3'h7
`define RTMR_STAT_RELOAD  0
`endif

// ---- rtmr_pkg.sv ----
package rtmr_pkg;
	typedef enum logic [1:0] {
		RTMR_ONE_SHOT,
		RTMR_CONTINUOUS,
		RTMR_COUNTER,
		RTMR_RESERVED
	} rtmr_mode_t;
endpackage : rtmr_pkg

// ---- rtmr_prescaler.sv ----
`include "rtmr_params.svh"
module rtmr_prescaler
	import rtmr_pkg::*;
#(
	parameter int PRE_BITS = 7
) (
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic       run,
	input  wire logic [2:0] div_log,
	output logic            tick
);
	initial begin
		if (PRE_BITS != 7) $error("prescaler must span 1..128");
	end

	logic [PRE_BITS-1:0] cnt_q;
	logic [PRE_BITS-1:0] limit;
	logic                wrap;

	// divide by 2**div_log, 1 to 128
	assign limit = PRE_BITS'((8'h01 << div_log) - 8'h01);
	assign wrap  = (cnt_q >= limit);
	assign tick  = run && wrap;

	always_ff @(posedge clk) begin
		if (srst || !run || wrap) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + PRE_BITS'(1);
		end
	end
endmodule : rtmr_prescaler

// ---- rtmr_timer.sv ----
// Function
// - sixteen-bit counter counting up on each qualified event.
// - prescaler divides system clock by 1 up to 128.
// - count wraps from ffff to 0000 and keeps going.
// - reload 0001 shortest, reload 0000 means full wrap, longest.
// - one-shot reload raises interrupt, count to 0001, clears enable.
// - one-shot output inverts for one clock at reload.
// - one-shot and continuous count prescaled clock only.
// - continuous reload raises interrupt, count to 0001, keeps running.
// - continuous output toggles at every reload.
// - written start count only first pass, then from 0001.
// - counter mode counts input edges chosen by polarity bit.
// - counter mode bypasses prescaler, one edge one count.
// - counter reload raises interrupt, count to 0001, toggles output.
// - polarity bit sets initial output level in counter mode.
//
// Added by the designer: the strobed register port and the register offsets.
`include "rtmr_params.svh"
module rtmr_timer
	import rtmr_pkg::*;
#(
	parameter int WIDTH = 16
) (
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic [7:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [15:0] rdata,
	input  wire logic        timer_in,
	output logic             timer_out,
	output logic             irq_pulse,
	output logic             irq
);
	initial begin
		if (WIDTH != 16) $error("counter width must be 16");
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [7:0]       ctrl_q;
	logic [WIDTH-1:0] count_q;
	logic [WIDTH-1:0] reload_q;
	logic             stat_q;
	logic             mask_q;
	logic             in_q;
	logic             in_prev_q;
	logic             out_lvl_q;

	wire rtmr_mode_t  mode     = rtmr_mode_t'(ctrl_q[`RTMR_CTRL_MODE_HI:`RTMR_CTRL_MODE_LO]);
	wire              enabled  = ctrl_q[`RTMR_CTRL_EN];
	wire              pol      = ctrl_q[`RTMR_CTRL_POL];
	wire              out_en   = ctrl_q[`RTMR_CTRL_OUTEN];
	wire [2:0]        div_log  = ctrl_q[`RTMR_CTRL_PRE_HI:`RTMR_CTRL_PRE_LO];
	wire              wr_ctrl  = wr && (addr == `RTMR_OFF_CTRL);
	wire              wr_count = wr && (addr == `RTMR_OFF_COUNT);
	wire              wr_rel   = wr && (addr == `RTMR_OFF_RELOAD);
	wire              wr_stat  = wr && (addr == `RTMR_OFF_STATUS);
	wire              wr_mask  = wr && (addr == `RTMR_OFF_MASK);

	// ----------------------------------------
	// count source
	// ----------------------------------------
	logic pre_tick;
	wire  is_counter = (mode == RTMR_COUNTER);

	rtmr_prescaler #(
		.PRE_BITS(7)
	) u_pre (
		.clk    (clk),
		.srst   (srst),
		.run    (enabled && !is_counter),
		.div_log(div_log),
		.tick   (pre_tick)
	);

	// inputs are synchronous; two stages, in_q and in_prev_q, to find the edge
	wire in_rise  = in_q && !in_prev_q;
	wire in_fall  = !in_q && in_prev_q;
	wire edge_hit = pol ? in_rise : in_fall;
	wire step     = enabled && (is_counter ? edge_hit : pre_tick);
	wire at_rel   = (count_q == reload_q);
	wire reload_ev = step && at_rel;

	// ----------------------------------------
	// counter and control
	// ----------------------------------------
	wire [WIDTH-1:0] count_d = reload_ev ? `RTMR_COUNT_RESTART
	                         : step ? count_q + WIDTH'(1)
	                         : count_q;
	wire             ctrl_clear_en = reload_ev && (mode == RTMR_ONE_SHOT);

	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl_q    <= `RTMR_CTRL_RST;
			count_q   <= `RTMR_COUNT_RST;
			reload_q  <= `RTMR_RELOAD_RST;
			mask_q    <= 1'b0;
			in_q      <= 1'b0;
			in_prev_q <= 1'b0;
		end else begin
			in_q      <= timer_in;
			in_prev_q <= in_q;
			if (wr_ctrl) begin
				ctrl_q <= wdata[7:0];
			end else if (ctrl_clear_en) begin
				ctrl_q[`RTMR_CTRL_EN] <= 1'b0;
			end
			count_q  <= wr_count ? wdata : count_d;
			if (wr_rel) begin
				reload_q <= wdata;
			end
			if (wr_mask) begin
				mask_q <= wdata[`RTMR_STAT_RELOAD];
			end
		end
	end

	// ----------------------------------------
	// output pin
	// ----------------------------------------
	// level is preset from polarity while disabled, so counter mode starts right
	always_ff @(posedge clk) begin
		if (srst) begin
			out_lvl_q <= 1'b0;
			timer_out <= 1'b0;
		end else begin
			if (!enabled) begin
				out_lvl_q <= pol;
			end else if (reload_ev && out_en && mode != RTMR_ONE_SHOT) begin
				out_lvl_q <= !out_lvl_q;
			end
			if (!out_en && !is_counter) begin
				timer_out <= pol;
			end else if (reload_ev && mode == RTMR_ONE_SHOT) begin
				timer_out <= !pol;
			end else if (mode == RTMR_ONE_SHOT) begin
				timer_out <= pol;
			end else if (reload_ev && out_en) begin
				timer_out <= !out_lvl_q;
			end else begin
				timer_out <= out_lvl_q;
			end
		end
	end

	// ----------------------------------------
	// interrupts and read port
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			stat_q    <= 1'b0;
			irq_pulse <= 1'b0;
			irq       <= 1'b0;
			rdata     <= 16'h0000;
		end else begin
			irq_pulse <= reload_ev;
			// set wins over write-one clear
			stat_q    <= reload_ev || (stat_q && !(wr_stat && wdata[`RTMR_STAT_RELOAD]));
			irq       <= (reload_ev || (stat_q && !(wr_stat && wdata[`RTMR_STAT_RELOAD])))
			             && (wr_mask ? wdata[`RTMR_STAT_RELOAD] : mask_q);
			if (rd) begin
				unique case (addr)
					`RTMR_OFF_CTRL:   rdata <= {8'h00, ctrl_q};
					`RTMR_OFF_COUNT:  rdata <= count_q;
					`RTMR_OFF_RELOAD: rdata <= reload_q;
					`RTMR_OFF_STATUS: rdata <= {15'h0000, stat_q};
					`RTMR_OFF_MASK:   rdata <= {15'h0000, mask_q};
					default:          rdata <= 16'h0000;
				endcase
			end else begin
				rdata <= 16'h0000;
			end
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	AST_ONESHOT_STOP: assert property (reload_ev && mode == RTMR_ONE_SHOT && !wr_ctrl |=> !enabled) else $error("one-shot did not stop");
	AST_RESTART: assert property (reload_ev && !wr_count |=> count_q == 16'h0001) else $error("reload not to 0001");
	AST_WRAP: assert property (step && !at_rel && count_q == 16'hffff && !wr_count |=> count_q == 16'h0000) else $error("no wrap");
	AST_HOLD: assert property (!enabled && !wr_count |=> $stable(count_q)) else $error("count moved while off");
	AST_PULSE: assert property (irq_pulse |=> !irq_pulse || $past(reload_ev)) else $error("pulse too long");
	AST_CONT_RUN: assert property (reload_ev && mode == RTMR_CONTINUOUS && !wr_ctrl |=> enabled) else $error("continuous stopped");
	AST_OS_BLIP: assert property (reload_ev && mode == RTMR_ONE_SHOT && out_en && !wr_ctrl |=> timer_out == !$past(pol) ##1 timer_out == $past(pol, 2)) else $error("one-shot blip wrong");
	AST_CNT_EDGE: assert property (enabled && is_counter && !edge_hit && !wr_count |=> $stable(count_q)) else $error("counted without edge");
	AST_TOGGLE: assert property (reload_ev && mode == RTMR_CONTINUOUS && out_en && !wr_ctrl |=> timer_out != $past(timer_out)) else $error("no toggle");

	COV_ONESHOT: cover property (reload_ev && mode == RTMR_ONE_SHOT);
	COV_CONT: cover property (reload_ev && mode == RTMR_CONTINUOUS);
	COV_COUNTER: cover property (reload_ev && is_counter);
	COV_IRQ: cover property (irq);
endmodule : rtmr_timer

// ---- rtmr_pin_model.sv ----
module rtmr_pin_model (
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic go,
	output logic      pin
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [4:0] left_q;
	logic [1:0] ph_q;
	// ----
	// pin source, seven pulses per burst
	// ----
	// four clocks per level keeps the rate well under a quarter of clk
	always @(posedge clk) begin
		ph_q <= srst ? 2'h0 : ph_q + 2'h1;
		if (srst) begin
			pin    <= 1'b0;
			left_q <= 5'h00;
		end else if (go) begin
			left_q <= 5'h0e;
		end else if (left_q != 5'h00 && ph_q == 2'h3) begin
			pin    <= ~pin;
			left_q <= left_q - 5'h01;
		end
	end
endmodule : rtmr_pin_model

// ---- rtmr_timer_tb.sv ----
`include "rtmr_params.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; \
	$display("[ERR] %0t got %h exp %h", $time, g, e); end end
module rtmr_timer_tb;
	import rtmr_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, go = 1'b0, rd_seen = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [15:0] wdata = 16'h0000, rdata, e, ctl, r, exp_q[$];
	logic        timer_in, timer_out, irq_pulse, irq;
	logic        po[$];
	int          err_count = 0, tests_run = 0, cyc = 0, low_n = 0, t0, base;
	int          seed = 32'hebcb;
	int          pt[$];
	logic [15:0] st[3] = '{16'h0001, 16'hfffe, 16'hffff};
	logic [15:0] rl[3] = '{16'h0002, 16'h0002, 16'h0000};
	int          lag[3] = '{0, 3, 0};
	rtmr_timer rtmr_timer_i (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .timer_in(timer_in), .timer_out(timer_out),
		.irq_pulse(irq_pulse), .irq(irq));
	rtmr_pin_model rtmr_pin_model_i (.clk(clk), .srst(srst), .go(go), .pin(timer_in));
	initial forever #50 clk = ~clk;
	// ----
	// watcher: read data, pulses, output level
	// ----
	always @(posedge clk) begin
		cyc <= cyc + 1;
		rd_seen <= rd;
		if (rd_seen) begin
			e = exp_q.pop_front();
			`CHK(rdata, e)
		end
		if (irq_pulse) begin
			pt.push_back(cyc);
			po.push_back(timer_out);
		end
		if (!timer_out) low_n++;
		if (cyc == 40000) begin
			err_count++;
			report_and_stop();
		end
	end
	// ----
	// bus cycles; a read notes its expectation
	// ----
	task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
		wr <= w;
		rd <= !w;
		addr <= a;
		wdata <= d;
		if (!w) exp_q.push_back(d);
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge clk);
	endtask : bus
	task automatic arm(input logic [15:0] c, input logic [15:0] n, input logic [15:0] m);
		bus(1'b1, `RTMR_OFF_CTRL, c);
		bus(1'b1, `RTMR_OFF_COUNT, n);
		bus(1'b1, `RTMR_OFF_RELOAD, m);
		pt.delete();
		po.delete();
		low_n = 0;
		bus(1'b1, `RTMR_OFF_CTRL, c | 16'h0001);
		t0 = cyc;
	endtask : arm
	// bounded wait; a missing pulse shows up in the compares
	task automatic upto(input int n);
		for (int i = 0; i < 3000 && pt.size() < n; i++) @(posedge clk);
	endtask : upto
	task automatic report_and_stop();
		if (err_count == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : report_and_stop
	// ----
	// scenarios
	// ----
	initial begin
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		for (int a = 0; a < 8; a++) bus(1'b0, 8'(a), 16'h0000);
		bus(1'b1, `RTMR_OFF_MASK, 16'h0001);
		for (int d = 0; d < 8; d++) begin
			r = 16'h0002 + 16'({$random(seed)} % 3);
			arm({8'h0, 2'b10, 3'(d), 2'(RTMR_CONTINUOUS), 1'b0}, 16'h0001, r);
			upto(3);
			`CHK(pt[2] - pt[1], int'(r) << d)
			`CHK(po[2] ^ po[1], 1'b1)
		end
		bus(1'b1, `RTMR_OFF_STATUS, 16'h0001);
		ctl = {8'h0, 2'b11, 3'h0, 2'(RTMR_ONE_SHOT), 1'b0};
		arm(ctl, 16'h0001, 16'h0004);
		upto(2);
		`CHK(pt.size(), 1)
		`CHK(low_n, 1)
		`CHK(irq, 1'b1)
		bus(1'b0, `RTMR_OFF_CTRL, ctl);
		bus(1'b0, `RTMR_OFF_COUNT, 16'h0001);
		bus(1'b1, `RTMR_OFF_STATUS, 16'h0001);
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b0)
		// start low, flip polarity once running: level stays high after time-out
		ctl = {8'h0, 2'b10, 3'h0, 2'(RTMR_ONE_SHOT), 1'b0};
		arm(ctl, 16'h0001, 16'h0008);
		bus(1'b1, `RTMR_OFF_CTRL, ctl | 16'h0041);
		upto(2);
		`CHK(timer_out, 1'b1)
		`CHK(pt.size(), 1)
		for (int k = 0; k < 3; k++) begin
			arm({8'h0, 2'b00, 3'h0, 2'(RTMR_CONTINUOUS), 1'b0}, st[k], rl[k]);
			upto(2);
			if (k == 0) base = pt[0] - t0;
			`CHK(pt[0] - t0, base + lag[k])
			if (k < 2) `CHK(pt[1] - pt[0], 2)
		end
		// prescale left at 128 to show it is bypassed
		for (int p = 0; p < 2; p++) begin
			ctl = {8'h0, 1'b0, 1'(p), 3'h7, 2'(RTMR_COUNTER), 1'b0};
			bus(1'b1, `RTMR_OFF_CTRL, ctl);
			repeat (2) @(posedge clk);
			`CHK(timer_out, 1'(p))
			arm(ctl, 16'h0001, 16'h0005);
			go <= 1'b1;
			@(posedge clk);
			go <= 1'b0;
			repeat (70) @(posedge clk);
			bus(1'b0, `RTMR_OFF_COUNT, 16'h0003);
			`CHK(pt.size(), 1)
		end
		report_and_stop();
	end
endmodule : rtmr_timer_tb
